// ---- logic/rxfb_top.sv ----
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// ==========================================================
// Receive buffer full flags
module rxfb_top #(
  parameter int NUM_BUF = rxfb_pkg::NUM_BUF,
  parameter int REG_W = rxfb_pkg::REG_W
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // Buffer-written strobes from the message store
  input wire logic [NUM_BUF-1:0] I_STORE_STB,
  // Register port
  input wire logic [rxfb_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [REG_W-1:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [REG_W-1:0] O_REG_RDATA,
  // Flag state towards the receive logic
  output logic [NUM_BUF-1:0] O_FULL_FLAGS,
  // Interrupt
  output logic O_IRQ
);

  // ==========================================================
  // Elaboration checks
  if (NUM_BUF != 2 * REG_W) begin : g_bad_num
    $error("NUM_BUF must be two register widths");
  end
  if (REG_W != rxfb_pkg::REG_W) begin : g_bad_width
    $error("REG_W must match the package width");
  end

  // ==========================================================
  // Local sizes
  localparam int CNT_W = $clog2(NUM_BUF + 1);
  localparam int IDX_W = $clog2(NUM_BUF);
  localparam int IRQ_W = rxfb_pkg::IRQ_W;

  // ==========================================================
  // Declarations
  rxfb_pkg::rxfb_reg_req_t req;

  logic wr_full_low;
  logic wr_full_high;
  logic wr_ovr_low;
  logic wr_ovr_high;
  logic wr_irq_status;
  logic wr_irq_mask;

  logic [NUM_BUF-1:0] flag_clr;
  logic [NUM_BUF-1:0] flags;
  logic [NUM_BUF-1:0] overrun;

  logic [NUM_BUF-1:0] ovr_q;
  logic [NUM_BUF-1:0] ovr_clr;

  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  logic all_full_q;
  logic all_full_now;

  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] count_q;
  logic [IDX_W-1:0] first_d;
  logic first_valid_d;
  logic [IDX_W-1:0] first_q;
  logic first_valid_q;

  logic [REG_W-1:0] rdata_d;
  logic [REG_W-1:0] rdata_q;

  // ==========================================================
  // Request carrier
  assign req.addr = I_REG_ADDR;
  assign req.wdata = I_REG_WDATA;
  assign req.wr = I_REG_WR;
  assign req.rd = I_REG_RD;

  // ==========================================================
  // Write decode
  always_comb begin
    wr_full_low = 1'b0;
    wr_full_high = 1'b0;
    wr_ovr_low = 1'b0;
    wr_ovr_high = 1'b0;
    wr_irq_status = 1'b0;
    wr_irq_mask = 1'b0;
    if (req.wr) begin
      case (req.addr)
        rxfb_pkg::ADDR_FULL_LOW: begin
          wr_full_low = 1'b1;
        end
        rxfb_pkg::ADDR_FULL_HIGH: begin
          wr_full_high = 1'b1;
        end
        rxfb_pkg::ADDR_OVR_LOW: begin
          wr_ovr_low = 1'b1;
        end
        rxfb_pkg::ADDR_OVR_HIGH: begin
          wr_ovr_high = 1'b1;
        end
        rxfb_pkg::ADDR_IRQ_STATUS: begin
          wr_irq_status = 1'b1;
        end
        rxfb_pkg::ADDR_IRQ_MASK: begin
          wr_irq_mask = 1'b1;
        end
        default: begin
          // Read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // ==========================================================
  // Flag clears: a zero bit clears, a one bit keeps
  always_comb begin
    flag_clr = '0;
    if (wr_full_low) begin
      flag_clr[REG_W-1:0] = ~req.wdata;
    end
    if (wr_full_high) begin
      flag_clr[NUM_BUF-1:REG_W] = ~req.wdata;
    end
  end

  // ==========================================================
  // Flag bank: flags are cleared only by the register write or by reset
  rxfb_flag_bank #(
    .NUM(NUM_BUF)
  ) u_flags (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_set(I_STORE_STB),
    .i_clr(flag_clr),
    .o_flags(flags),
    .o_overrun(overrun)
  );

  // ==========================================================
  // Overrun record: store into a still-full buffer, write one to clear
  always_comb begin
    ovr_clr = '0;
    if (wr_ovr_low) begin
      ovr_clr[REG_W-1:0] = req.wdata;
    end
    if (wr_ovr_high) begin
      ovr_clr[NUM_BUF-1:REG_W] = req.wdata;
    end
  end

  // Sticky overrun bits, a new overrun beats a clear
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ovr_q <= {rxfb_pkg::OVR_RESET, rxfb_pkg::OVR_RESET};
    end else begin
      ovr_q <= (ovr_q & ~ovr_clr) | overrun;
    end
  end

  // ==========================================================
  // All-full detection for its rising edge
  assign all_full_now = &flags;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      all_full_q <= 1'b0;
    end else begin
      all_full_q <= all_full_now;
    end
  end

  // ==========================================================
  // Interrupt events
  always_comb begin
    irq_event = '0;
    irq_event[rxfb_pkg::IRQ_STORED] = |I_STORE_STB;
    irq_event[rxfb_pkg::IRQ_OVERRUN] = |overrun;
    irq_event[rxfb_pkg::IRQ_ALL_FULL] = all_full_now & ~all_full_q;
    irq_event[rxfb_pkg::IRQ_RELEASED] = |(flag_clr & flags & ~I_STORE_STB);
  end

  // Status clear: write one to a bit
  always_comb begin
    irq_clr = '0;
    if (wr_irq_status) begin
      irq_clr = req.wdata[IRQ_W-1:0];
    end
  end

  rxfb_irq #(
    .W(IRQ_W)
  ) u_irq (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_event(irq_event),
    .i_status_clr(irq_clr),
    .i_mask_we(wr_irq_mask),
    .i_mask_wdata(req.wdata[IRQ_W-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(O_IRQ)
  );

  // ==========================================================
  // Number of full buffers
  always_comb begin
    count_d = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      count_d = count_d + CNT_W'(flags[i]);
    end
  end

  // Lowest-numbered full buffer
  always_comb begin
    first_d = '0;
    first_valid_d = 1'b0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (flags[i]) begin
        first_d = IDX_W'(i);
        first_valid_d = 1'b1;
      end
    end
  end

  // Summary registers, one cycle behind the flags
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      count_q <= '0;
      first_q <= '0;
      first_valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      first_q <= first_d;
      first_valid_q <= first_valid_d;
    end
  end

  // ==========================================================
  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = rxfb_pkg::RDATA_IDLE;
    case (req.addr)
      rxfb_pkg::ADDR_FULL_LOW: begin
        rdata_d = flags[REG_W-1:0];
      end
      rxfb_pkg::ADDR_FULL_HIGH: begin
        rdata_d = flags[NUM_BUF-1:REG_W];
      end
      rxfb_pkg::ADDR_OVR_LOW: begin
        rdata_d = ovr_q[REG_W-1:0];
      end
      rxfb_pkg::ADDR_OVR_HIGH: begin
        rdata_d = ovr_q[NUM_BUF-1:REG_W];
      end
      rxfb_pkg::ADDR_IRQ_STATUS: begin
        rdata_d = REG_W'(irq_status);
      end
      rxfb_pkg::ADDR_IRQ_MASK: begin
        rdata_d = REG_W'(irq_mask);
      end
      rxfb_pkg::ADDR_FULL_COUNT: begin
        rdata_d = REG_W'(count_q);
      end
      rxfb_pkg::ADDR_FIRST_FULL: begin
        rdata_d = REG_W'(first_q);
        rdata_d[rxfb_pkg::FIRST_VALID_BIT] = first_valid_q;
      end
      default: begin
        rdata_d = rxfb_pkg::RDATA_IDLE;
      end
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      rdata_q <= rxfb_pkg::RDATA_IDLE;
    end else if (req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= rxfb_pkg::RDATA_IDLE;
    end
  end

  // ==========================================================
  // Outputs
  assign O_REG_RDATA = rdata_q;
  assign O_FULL_FLAGS = flags;

endmodule

// ---- logic/rxfb_pkg.sv ----
package rxfb_pkg;

  // ==========================================================
  // Sizes
  localparam int REG_W = 16;
  localparam int ADDR_W = 4;
  localparam int NUM_BUF = 32;
  localparam int IRQ_W = 4;

  // ==========================================================
  // Register word indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_FULL_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FULL_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_OVR_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OVR_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_FULL_COUNT = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_FULL = 4'h7;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] FULL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] OVR_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [REG_W-1:0] RDATA_IDLE = 16'h0000;

  // ==========================================================
  // Interrupt status bit positions
  localparam int IRQ_STORED = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_ALL_FULL = 2;
  localparam int IRQ_RELEASED = 3;

  // First-full register: valid flag position
  localparam int FIRST_VALID_BIT = 15;

  // ==========================================================
  // One register request as seen in a cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } rxfb_reg_req_t;

endpackage

// ---- logic/rxfb_flag_bank.sv ----
`timescale 1ns/1ps

// Bank of buffer-full flags, set by hardware, cleared by software
module rxfb_flag_bank #(
  parameter int NUM = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Set and clear requests, one bit per buffer
  input wire logic [NUM-1:0] i_set,
  input wire logic [NUM-1:0] i_clr,
  // Flag state and store-into-full indication
  output logic [NUM-1:0] o_flags,
  output logic [NUM-1:0] o_overrun
);

  logic [NUM-1:0] flag_q;

  // ==========================================================
  // One flag flop per buffer
  for (genvar g = 0; g < NUM; g++) begin : g_flag
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        flag_q[g] <= 1'b0;
      end else if (i_set[g]) begin
        flag_q[g] <= 1'b1;
      end else if (i_clr[g]) begin
        flag_q[g] <= 1'b0;
      end
    end
  end

  // Flag state straight from the flops
  assign o_flags = flag_q;
  // A store into a buffer still marked full
  assign o_overrun = i_set & flag_q;

endmodule

// ---- logic/rxfb_irq.sv ----
`timescale 1ns/1ps

// Sticky event status, mask and one level interrupt
module rxfb_irq #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Event pulses from the block
  input wire logic [W-1:0] i_event,
  // Write-one-to-clear of status bits
  input wire logic [W-1:0] i_status_clr,
  // Mask write
  input wire logic i_mask_we,
  input wire logic [W-1:0] i_mask_wdata,
  // State and interrupt
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_mask,
  output logic o_irq
);

  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;
  logic irq_q;

  // Set wins over a clear in the same cycle
  assign status_d = (status_q & ~i_status_clr) | i_event;

  // Sticky status register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_q <= rxfb_pkg::IRQ_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Mask register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_q <= rxfb_pkg::IRQ_MASK_RESET;
    end else if (i_mask_we) begin
      mask_q <= i_mask_wdata;
    end
  end

  // Registered interrupt level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign o_status = status_q;
  assign o_mask = mask_q;
  assign o_irq = irq_q;

endmodule

// ---- tb/rxfb_props.sv ----
`timescale 1ns/1ps

// ==========================================================
// Flag bank checks on the top ports
module rxfb_props #(
  parameter int NUM_BUF = 32,
  parameter int REG_W = 16
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // Inputs
  input wire logic [NUM_BUF-1:0] I_STORE_STB,
  input wire logic [rxfb_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [REG_W-1:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  // Outputs
  input wire logic [REG_W-1:0] O_REG_RDATA,
  input wire logic [NUM_BUF-1:0] O_FULL_FLAGS,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  // Bits kept through a cycle, per half
  logic wr_lo;
  logic wr_hi;
  logic [REG_W-1:0] keep_lo;
  logic [REG_W-1:0] keep_hi;
  logic [REG_W-1:0] fl_lo;
  logic [REG_W-1:0] fl_hi;
  assign wr_lo = I_REG_WR && I_REG_ADDR == rxfb_pkg::ADDR_FULL_LOW;
  assign wr_hi = I_REG_WR && I_REG_ADDR == rxfb_pkg::ADDR_FULL_HIGH;
  assign keep_lo = wr_lo ? I_REG_WDATA : '1;
  assign keep_hi = wr_hi ? I_REG_WDATA : '1;
  assign fl_lo = O_FULL_FLAGS[REG_W-1:0];
  assign fl_hi = O_FULL_FLAGS[NUM_BUF-1:REG_W];

  chk_store_sets: assert property (I_STORE_STB != '0 |=>
    (O_FULL_FLAGS & $past(I_STORE_STB)) == $past(I_STORE_STB))
    else $error("store did not set its flag");
  chk_no_sw_set: assert property (1'b1 |=>
    (O_FULL_FLAGS & ~$past(O_FULL_FLAGS) & ~$past(I_STORE_STB)) == '0)
    else $error("flag rose without a store");
  chk_low_keep: assert property (1'b1 |=>
    (~fl_lo & $past(fl_lo) & $past(keep_lo)) == '0)
    else $error("low flag lost without a zero write");
  chk_high_keep: assert property (1'b1 |=>
    (~fl_hi & $past(fl_hi) & $past(keep_hi)) == '0)
    else $error("high flag lost without a zero write");
  chk_low_clear: assert property (wr_lo |=>
    (fl_lo & ~$past(I_REG_WDATA) & ~$past(I_STORE_STB[REG_W-1:0])) == '0)
    else $error("low zero write did not clear");
  chk_high_clear: assert property (wr_hi |=>
    (fl_hi & ~$past(I_REG_WDATA)
      & ~$past(I_STORE_STB[NUM_BUF-1:REG_W])) == '0)
    else $error("high zero write did not clear");
  chk_read_low: assert property (I_REG_RD &&
    I_REG_ADDR == rxfb_pkg::ADDR_FULL_LOW |=> O_REG_RDATA == $past(fl_lo))
    else $error("low read data wrong");
  chk_read_high: assert property (I_REG_RD &&
    I_REG_ADDR == rxfb_pkg::ADDR_FULL_HIGH |=> O_REG_RDATA == $past(fl_hi))
    else $error("high read data wrong");
  chk_rdata_idle: assert property (!I_REG_RD |=> O_REG_RDATA == '0)
    else $error("read data not idle");
  chk_irq_cause: assert property ($rose(O_IRQ) |->
    $past(I_STORE_STB != '0) || $past(I_STORE_STB != '0, 2)
      || $past(I_REG_WR))
    else $error("interrupt rose with no cause");
endmodule

bind rxfb_top rxfb_props #(.NUM_BUF(NUM_BUF), .REG_W(REG_W)) rxfb_props_i (
  .I_CLK_SYS(I_CLK_SYS),
  .I_SYS_RST(I_SYS_RST),
  .I_STORE_STB(I_STORE_STB),
  .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WDATA(I_REG_WDATA),
  .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA),
  .O_FULL_FLAGS(O_FULL_FLAGS),
  .O_IRQ(O_IRQ)
);

// ---- tb/rxfb_top_test.sv ----
`timescale 1ns/1ps

// ==========================================================
// Flag bank bench
module rxfb_top_test;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic irq;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [31:0] stb;
  logic [31:0] flags;
  logic [31:0] exp_fl;
  int err_total;
  int check_count;
  localparam logic [3:0] LO = rxfb_pkg::ADDR_FULL_LOW;
  localparam logic [3:0] HI = rxfb_pkg::ADDR_FULL_HIGH;

  rxfb_top rxfb_top_i (
    .I_CLK_SYS(clk),
    .I_SYS_RST(rst),
    .I_STORE_STB(stb),
    .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata),
    .I_REG_WR(wr),
    .I_REG_RD(rd),
    .O_REG_RDATA(rdata),
    .O_FULL_FLAGS(flags),
    .O_IRQ(irq)
  );

  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare tasks
  task automatic cmp16(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Register port and store strobe drivers
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] want);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp16(rdata, want);
  endtask

  task automatic store(input logic [31:0] s);
    @(posedge clk);
    stb <= s;
    @(posedge clk);
    stb <= 32'h0;
    #1;
  endtask

  // Verdict and end of run
  task final_report;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    final_report;
  end

  // Main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    stb = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp32(flags, 32'h0);
    rd_chk(LO, 16'h0000);
    rd_chk(HI, 16'h0000);
    $display("test reset done");
    exp_fl = 32'h0;
    for (int n = 0; n < 32; n++) begin
      store(32'h1 << n);
      exp_fl |= 32'h1 << n;
      cmp32(flags, exp_fl);
    end
    rd_chk(LO, 16'hFFFF);
    rd_chk(HI, 16'hFFFF);
    $display("test store walk done");
    reg_wr(LO, 16'hFFFF);
    cmp32(flags, 32'hFFFFFFFF);
    reg_wr(LO, 16'hFFFE);
    cmp32(flags, 32'hFFFFFFFE);
    reg_wr(HI, 16'h7FFF);
    cmp32(flags, 32'h7FFFFFFE);
    rd_chk(LO, 16'hFFFE);
    rd_chk(HI, 16'h7FFF);
    reg_wr(HI, 16'h0000);
    cmp32(flags, 32'h0000FFFE);
    reg_wr(4'hA, 16'h0000);
    cmp32(flags, 32'h0000FFFE);
    rd_chk(4'hA, 16'h0000);
    repeat (10) @(posedge clk);
    #1;
    cmp32(flags, 32'h0000FFFE);
    $display("test clear done");
    @(posedge clk);
    addr <= LO;
    wdata <= 16'h0000;
    wr <= 1'b1;
    stb <= 32'h00100008;
    @(posedge clk);
    wr <= 1'b0;
    stb <= 32'h0;
    #1;
    cmp32(flags, 32'h00100008);
    $display("test set wins done");
    rd_chk(rxfb_pkg::ADDR_OVR_LOW, 16'h0008);
    rd_chk(rxfb_pkg::ADDR_OVR_HIGH, 16'h0000);
    reg_wr(rxfb_pkg::ADDR_OVR_LOW, 16'h0008);
    rd_chk(rxfb_pkg::ADDR_OVR_LOW, 16'h0000);
    reg_wr(rxfb_pkg::ADDR_FULL_COUNT, 16'hFFFF);
    rd_chk(rxfb_pkg::ADDR_FULL_COUNT, 16'h0002);
    rd_chk(rxfb_pkg::ADDR_FIRST_FULL, 16'h8003);
    rd_chk(rxfb_pkg::ADDR_IRQ_STATUS, 16'h000F);
    $display("test summary done");
    reg_wr(rxfb_pkg::ADDR_IRQ_STATUS, 16'h000F);
    @(posedge clk);
    #1;
    cmp32({31'h0, irq}, 32'h0);
    reg_wr(rxfb_pkg::ADDR_IRQ_MASK, 16'h0001);
    rd_chk(rxfb_pkg::ADDR_IRQ_MASK, 16'h0001);
    store(32'h00000080);
    cmp32(flags, 32'h00100088);
    @(posedge clk);
    #1;
    cmp32({31'h0, irq}, 32'h1);
    reg_wr(rxfb_pkg::ADDR_IRQ_STATUS, 16'h000F);
    @(posedge clk);
    #1;
    cmp32({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    final_report;
  end
endmodule
